// [verilog/tselic_map.svh]
`ifndef TSELIC_MAP_SVH
`define TSELIC_MAP_SVH

// ----------------------------------------------------------------
// interrupt codes and steps
// ----------------------------------------------------------------
`define TSELIC_CODE_TIMEOUT   8'h2c
`define TSELIC_CODE_ARB_SEL   8'h64
`define TSELIC_CODE_LONG_MSG  8'h67
`define TSELIC_CODE_SEL       8'h80
`define TSELIC_CODE_SEL_ATN   8'h81
`define TSELIC_CODE_BUSY_CMD  8'h84
`define TSELIC_CODE_BUSY_MOUT 8'h85
`define TSELIC_STEP_NONE      8'h00
`define TSELIC_STEP_MOUT      8'h81
`define TSELIC_STEP_ID_ATN    8'h82
`define TSELIC_STEP_ID_CMD    8'h93
`define TSELIC_STEP_CMD_PH    8'hb1
`define TSELIC_STEP_CMD_ATN   8'hb2

// ----------------------------------------------------------------
// message layout
// ----------------------------------------------------------------
`define TSELIC_EXT_MSG_CODE   8'h01
`define TSELIC_EXT_LEN_LIMIT  8'h1f
`define TSELIC_KEEP_BYTES     2'd2
`define TSELIC_RESET_BYTE     8'h00
`endif

// [verilog/tselic_pkg.sv]
package tselic_pkg;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] step;
  } tselic_report_t;

  typedef struct packed {
    logic sel;
    logic sel_atn;
    logic ident_rx;
    logic cmd_rx;
    logic atn_seen;
    logic to_cmd;
    logic to_msgout;
    logic to_msgin;
    logic timeout;
    logic msg_try;
    logic arb_sel;
    logic op_done;
    logic cmd_late;
  } tselic_event_t;

  typedef struct packed {
    logic phase_msg_cmd;
    logic auto_rx;
    logic auto_sel;
  } tselic_mode_t;

  typedef enum logic [1:0] {
    TSELIC_PH_IDLE,
    TSELIC_PH_CMD,
    TSELIC_PH_MSGOUT,
    TSELIC_PH_MSGIN
  } tselic_phase_t;

endpackage

// [verilog/tselic_mem.sv]
module tselic_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             clk_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
    rd_data_reg <= mem_reg[rd_addr_i];
  end

  assign rd_data_o = rd_data_reg;
endmodule

// [verilog/tselic_top.sv]
`include "tselic_map.svh"

module tselic_top #(
  parameter int QDEPTH = 4,
  parameter int QAW    = 2
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire tselic_pkg::tselic_event_t ev_i,
  input  wire tselic_pkg::tselic_mode_t  mode_i,
  input  wire logic                      buf_busy_i,
  input  wire logic                      msg_byte_stb_i,
  input  wire logic [7:0]                msg_byte_i,
  input  wire logic                      report_ack_i,
  output tselic_pkg::tselic_report_t     report_o,
  output logic                           report_valid_o,
  output logic                           byte_ack_o,
  output logic                           abort_o,
  output logic                           msg_refused_o,
  output logic                           overflow_o
);
  import tselic_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic tselic_report_t make_rep(input logic [7:0] c,
                                              input logic [7:0] s);
    tselic_report_t r;
    r.code = c;
    r.step = s;
    return r;
  endfunction

  function automatic logic [QAW-1:0] ptr_inc(input logic [QAW-1:0] p);
    return (p == QAW'(QDEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // nexus context
  // ----------------------------------------------------------------
  tselic_phase_t phase_reg, phase_next;
  logic          ident_reg, ident_next;
  logic          cmd_reg,   cmd_next;
  logic          atn_reg,   atn_next;
  logic          late_reg,  late_next;

  // ----------------------------------------------------------------
  // message byte tracking
  // ----------------------------------------------------------------
  logic [1:0] bcnt_reg,  bcnt_next;
  logic       ext_reg,   ext_next;
  logic       long_reg,  long_next;
  logic       dead_reg,  dead_next;
  logic       long_hit;

  // ----------------------------------------------------------------
  // report queue and output
  // ----------------------------------------------------------------
  logic [QAW-1:0] wp_reg, wp_next;
  logic [QAW-1:0] rp_reg, rp_next;
  logic [QAW:0]   cnt_reg, cnt_next;
  logic           pend_reg, pend_next;
  tselic_report_t out_reg, out_next;
  logic           val_reg, val_next;
  logic           ovf_reg, ovf_next;
  logic           back_reg, back_next;
  logic           abort_reg, abort_next;
  logic           ref_reg, ref_next;
  tselic_report_t push_rep;
  logic           push;
  logic           pop;
  logic [15:0]    head;

  // ----------------------------------------------------------------
  // report store, read data registered inside
  // ----------------------------------------------------------------
  tselic_mem #(
    .WIDTH (16),
    .DEPTH (QDEPTH),
    .AW    (QAW)
  ) tselic_mem_i (
    .clk_i     (clk_i),
    .wr_en_i   (push && !cnt_reg[QAW]),
    .wr_addr_i (wp_reg),
    .wr_data_i (push_rep),
    .rd_addr_i (rp_reg),
    .rd_data_o (head)
  );

  // ----------------------------------------------------------------
  // byte tracking: long extended message kept to two bytes
  // ----------------------------------------------------------------
  always_comb begin
    bcnt_next = bcnt_reg;
    ext_next  = ext_reg;
    long_next = long_reg;
    dead_next = dead_reg;
    back_next = 1'b0;
    long_hit  = 1'b0;
    // a long message closes the byte path and later timeout reports; a timeout does the same
    if (ev_i.sel || ev_i.to_cmd || ev_i.to_msgout || ev_i.to_msgin) begin
      bcnt_next = '0;
      ext_next  = 1'b0;
      long_next = 1'b0;
      dead_next = 1'b0;
    end else if (msg_byte_stb_i && !dead_reg && !long_reg) begin
      back_next = 1'b1;
      if (bcnt_reg == 2'd0) begin
        ext_next = (msg_byte_i == `TSELIC_EXT_MSG_CODE);
      end
      // length byte counts the bytes after itself: 31 means 33 total
      if (bcnt_reg == 2'd1 && ext_reg &&
          msg_byte_i >= `TSELIC_EXT_LEN_LIMIT) begin
        long_next = 1'b1;
        long_hit  = 1'b1;
      end
      if (bcnt_reg != `TSELIC_KEEP_BYTES) begin
        bcnt_next = bcnt_reg + 2'd1;
      end
    end else if (ev_i.timeout) begin
      dead_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // context and report selection
  // ----------------------------------------------------------------
  always_comb begin
    phase_next = phase_reg;
    ident_next = ident_reg;
    cmd_next   = cmd_reg;
    atn_next   = atn_reg;
    late_next  = late_reg;
    push       = 1'b0;
    push_rep   = make_rep(`TSELIC_STEP_NONE, `TSELIC_STEP_NONE);
    abort_next = 1'b0;
    ref_next   = 1'b0;

    if (ev_i.sel) begin
      phase_next = TSELIC_PH_IDLE;
      ident_next = 1'b0;
      cmd_next   = 1'b0;
      atn_next   = ev_i.sel_atn;
    end
    if (ev_i.ident_rx) ident_next = 1'b1;
    if (ev_i.cmd_rx)   cmd_next   = 1'b1;
    if (ev_i.atn_seen) atn_next   = 1'b1;
    if (ev_i.to_cmd)    phase_next = TSELIC_PH_CMD;
    if (ev_i.to_msgout) phase_next = TSELIC_PH_MSGOUT;
    if (ev_i.to_msgin)  phase_next = TSELIC_PH_MSGIN;
    if (ev_i.cmd_late)  late_next  = 1'b1;

    // one report per cycle; earlier branches win
    if (ev_i.arb_sel) begin
      push     = 1'b1;
      push_rep = make_rep(`TSELIC_CODE_ARB_SEL, `TSELIC_STEP_NONE);
    end else if (ev_i.op_done && late_reg) begin
      push      = 1'b1;
      // a late command in the same cycle re-arms the flag
      late_next = ev_i.cmd_late;
      push_rep  = make_rep(`TSELIC_CODE_ARB_SEL, `TSELIC_STEP_NONE);
    end else if (ev_i.timeout && !dead_reg && !long_reg) begin
      abort_next = 1'b1;
      if (phase_reg == TSELIC_PH_CMD && mode_i.phase_msg_cmd) begin
        push     = 1'b1;
        push_rep = make_rep(`TSELIC_CODE_TIMEOUT, `TSELIC_STEP_CMD_PH);
      end else if (phase_reg == TSELIC_PH_MSGIN && cmd_reg && atn_reg &&
                   !ident_reg && mode_i.phase_msg_cmd &&
                   mode_i.auto_rx) begin
        push     = 1'b1;
        push_rep = make_rep(`TSELIC_CODE_TIMEOUT, `TSELIC_STEP_CMD_ATN);
      end
    end else if (long_hit) begin
      abort_next = 1'b1;
      push_rep.code = `TSELIC_CODE_LONG_MSG;
      if (phase_reg == TSELIC_PH_MSGOUT) begin
        push          = 1'b1;
        push_rep.step = `TSELIC_STEP_MOUT;
      end else if (phase_reg == TSELIC_PH_MSGIN && ident_reg && cmd_reg &&
                   atn_reg) begin
        push          = 1'b1;
        push_rep.step = `TSELIC_STEP_ID_CMD;
      end else if (phase_reg == TSELIC_PH_MSGIN && ident_reg &&
                   atn_reg) begin
        push          = 1'b1;
        push_rep.step = `TSELIC_STEP_ID_ATN;
      end else if (phase_reg == TSELIC_PH_MSGIN && cmd_reg && atn_reg &&
                   mode_i.phase_msg_cmd && mode_i.auto_rx) begin
        push          = 1'b1;
        push_rep.step = `TSELIC_STEP_CMD_ATN;
      end
    end else if (ev_i.sel) begin
      if (!mode_i.auto_sel) begin
        push     = 1'b1;
        push_rep = ev_i.sel_atn ?
                   make_rep(`TSELIC_CODE_SEL_ATN, `TSELIC_STEP_NONE) :
                   make_rep(`TSELIC_CODE_SEL, `TSELIC_STEP_NONE);
      end
    end else if (ev_i.msg_try && buf_busy_i) begin
      if (atn_reg) begin
        push     = 1'b1;
        ref_next = 1'b1;
        push_rep = make_rep(`TSELIC_CODE_BUSY_MOUT, `TSELIC_STEP_NONE);
      end else if (mode_i.phase_msg_cmd) begin
        push     = 1'b1;
        ref_next = 1'b1;
        push_rep = make_rep(`TSELIC_CODE_BUSY_CMD, `TSELIC_STEP_NONE);
      end
    end
  end

  // ----------------------------------------------------------------
  // queue bookkeeping; the read port is registered, so the head is
  // fetched a cycle before it is moved to the output pair
  // ----------------------------------------------------------------
  always_comb begin
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    cnt_next  = cnt_reg;
    pend_next = pend_reg;
    out_next  = out_reg;
    val_next  = val_reg;
    ovf_next  = ovf_reg;
    pop       = 1'b0;
    if (report_ack_i && val_reg) val_next = 1'b0;
    if (pend_reg) begin
      out_next  = head;
      val_next  = 1'b1;
      pend_next = 1'b0;
      pop       = 1'b1;
      rp_next   = ptr_inc(rp_reg);
    end else if (cnt_reg != '0 && !val_next) begin
      pend_next = 1'b1;
    end
    if (push) begin
      if (cnt_reg[QAW]) begin
        ovf_next = 1'b1;  // limitation: report lost when queue is full
      end else begin
        wp_next = ptr_inc(wp_reg);
      end
    end
    cnt_next = cnt_reg + (QAW+1)'(push && !cnt_reg[QAW]) - (QAW+1)'(pop);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= TSELIC_PH_IDLE;
      ident_reg <= 1'b0;
      cmd_reg   <= 1'b0;
      atn_reg   <= 1'b0;
      late_reg  <= 1'b0;
      bcnt_reg  <= '0;
      ext_reg   <= 1'b0;
      long_reg  <= 1'b0;
      dead_reg  <= 1'b0;
      back_reg  <= 1'b0;
      abort_reg <= 1'b0;
      ref_reg   <= 1'b0;
      wp_reg    <= '0;
      rp_reg    <= '0;
      cnt_reg   <= '0;
      pend_reg  <= 1'b0;
      out_reg   <= make_rep(`TSELIC_RESET_BYTE, `TSELIC_RESET_BYTE);
      val_reg   <= 1'b0;
      ovf_reg   <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      ident_reg <= ident_next;
      cmd_reg   <= cmd_next;
      atn_reg   <= atn_next;
      late_reg  <= late_next;
      bcnt_reg  <= bcnt_next;
      ext_reg   <= ext_next;
      long_reg  <= long_next;
      dead_reg  <= dead_next;
      back_reg  <= back_next;
      abort_reg <= abort_next;
      ref_reg   <= ref_next;
      wp_reg    <= wp_next;
      rp_reg    <= rp_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      out_reg   <= out_next;
      val_reg   <= val_next;
      ovf_reg   <= ovf_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a register
  // ----------------------------------------------------------------
  assign report_o       = out_reg;
  assign report_valid_o = val_reg;
  assign byte_ack_o     = back_reg;
  assign abort_o        = abort_reg;
  assign msg_refused_o  = ref_reg;
  assign overflow_o     = ovf_reg;
endmodule

// [testbench/tselic_props.sv]
module tselic_props (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire tselic_pkg::tselic_event_t  ev_i,
  input wire logic                       buf_busy_i,
  input wire logic                       msg_byte_stb_i,
  input wire logic                       report_ack_i,
  input wire tselic_pkg::tselic_report_t report_o,
  input wire logic                       report_valid_o,
  input wire logic                       byte_ack_o,
  input wire logic                       abort_o,
  input wire logic                       msg_refused_o,
  input wire logic                       overflow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tselic_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_hold;
    report_valid_o && !report_ack_i |=> report_valid_o && $stable(report_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pair changed");
  property p_drop;
    report_valid_o && report_ack_i |=> !report_valid_o;
  endproperty
  a_drop: assert property (p_drop) else $error("ack ignored");
  property p_zero_step;
    report_valid_o && report_o.code inside {8'h64, 8'h80, 8'h81, 8'h84, 8'h85}
      |-> report_o.step == 8'h00;
  endproperty
  a_zero_step: assert property (p_zero_step) else $error("step not 00");
  property p_tmo;
    report_valid_o && report_o.code == 8'h2c |-> report_o.step inside {8'hb1, 8'hb2};
  endproperty
  a_tmo: assert property (p_tmo) else $error("bad timeout step");
  property p_long;
    report_valid_o && report_o.code == 8'h67
      |-> report_o.step inside {8'h81, 8'h82, 8'h93, 8'hb2};
  endproperty
  a_long: assert property (p_long) else $error("bad long step");
  property p_bya;
    byte_ack_o |-> $past(msg_byte_stb_i);
  endproperty
  a_bya: assert property (p_bya) else $error("ack without byte");
  property p_abort;
    abort_o |-> $past(ev_i.timeout || msg_byte_stb_i);
  endproperty
  a_abort: assert property (p_abort) else $error("abort without cause");
  property p_refuse;
    msg_refused_o |-> $past(ev_i.msg_try && buf_busy_i);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal without cause");
  property p_ovf;
    overflow_o |=> overflow_o;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow cleared");
  c_read: cover property (report_valid_o && report_ack_i);
  c_abort: cover property (abort_o);
  c_refuse: cover property (msg_refused_o);
endmodule

// [testbench/tselic_initiator.sv]
module tselic_initiator (
  input  wire logic                 clk_i,
  output tselic_pkg::tselic_event_t ev_o,
  output logic                      stb_o,
  output logic [7:0]                byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tselic_pkg::*;
  initial begin
    ev_o = '0;
    stb_o = 1'b0;
    byte_o = 8'ha5;
  end
  task automatic pulse(input tselic_event_t e);
    @(negedge clk_i);
    ev_o = e;
    @(negedge clk_i);
    ev_o = '0;
  endtask
  // byte 0 = 01h marks an extended message, byte 1 its length
  task automatic send(input logic [7:0] b[$]);
    foreach (b[k]) begin
      @(negedge clk_i);
      stb_o = 1'b1;
      byte_o = b[k];
    end
    @(negedge clk_i);
    stb_o = 1'b0;
    // released data line must not keep the last byte
    byte_o = ~byte_o;
  endtask
endmodule

// [testbench/tselic_bench.sv]
module tselic_bench import tselic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam tselic_event_t E_SEL  = '{sel: 1'b1, default: 1'b0};
  localparam tselic_event_t E_SELA = '{sel: 1'b1, sel_atn: 1'b1, default: 1'b0};
  localparam tselic_event_t E_CMD  = '{to_cmd: 1'b1, default: 1'b0};
  localparam tselic_event_t E_MOUT = '{to_msgout: 1'b1, default: 1'b0};
  localparam tselic_event_t E_TMO  = '{timeout: 1'b1, default: 1'b0};
  localparam tselic_event_t E_TRY  = '{msg_try: 1'b1, default: 1'b0};
  localparam tselic_event_t E_ARB  = '{arb_sel: 1'b1, default: 1'b0};
  localparam tselic_event_t E_LATE = '{cmd_late: 1'b1, default: 1'b0};
  localparam tselic_event_t E_DONE = '{op_done: 1'b1, default: 1'b0};
  logic           clk_i, rst_i, buf_busy_i, report_ack_i, stb;
  logic           report_valid_o, byte_ack_o, abort_o, msg_refused_o;
  logic           overflow_o;
  logic [7:0]     mbyte;
  tselic_mode_t   mode_i;
  tselic_event_t  ev;
  tselic_report_t report_o;
  int             n_errors = 0, compares = 0, acks = 0, aborts = 0, refs = 0;
  tselic_top tselic_top_i (.clk_i(clk_i), .rst_i(rst_i), .ev_i(ev),
    .mode_i(mode_i), .buf_busy_i(buf_busy_i), .msg_byte_stb_i(stb),
    .msg_byte_i(mbyte), .report_ack_i(report_ack_i), .report_o(report_o),
    .report_valid_o(report_valid_o), .byte_ack_o(byte_ack_o),
    .abort_o(abort_o), .msg_refused_o(msg_refused_o),
    .overflow_o(overflow_o));
  tselic_initiator tselic_initiator_i (.clk_i(clk_i), .ev_o(ev),
    .stb_o(stb), .byte_o(mbyte));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (byte_ack_o === 1'b1) acks++;
    if (abort_o === 1'b1) aborts++;
    if (msg_refused_o === 1'b1) refs++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // host side: wait for a pair, compare it, read it away
  // ----------------------------------------------------------------
  task automatic expect_rep(input logic [15:0] exp);
    int k;
    k = 0;
    while (report_valid_o !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    check(report_valid_o === 1'b1 ? report_o : 16'hxxxx, exp);
    report_ack_i = 1'b1;
    @(negedge clk_i);
    report_ack_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic expect_none;
    repeat (8) @(negedge clk_i);
    check({15'h0, report_valid_o}, 16'h0000);
  endtask
  task automatic to_msgin;
    tselic_initiator_i.pulse(E_SEL);
    tselic_initiator_i.pulse('{cmd_rx: 1'b1, default: 1'b0});
    tselic_initiator_i.pulse('{atn_seen: 1'b1, default: 1'b0});
    tselic_initiator_i.pulse('{to_msgin: 1'b1, default: 1'b0});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_plain_sel;
    mode_i = 3'h6;
    tselic_initiator_i.pulse(E_SEL);
    expect_rep(16'h8000);
    tselic_initiator_i.pulse(E_SELA);
    expect_rep(16'h8100);
    mode_i = 3'h7;
    tselic_initiator_i.pulse(E_SELA);
    expect_none();
  endtask
  task automatic t_timeout;
    int a0;
    a0 = aborts;
    tselic_initiator_i.pulse(E_SEL);
    tselic_initiator_i.pulse(E_CMD);
    tselic_initiator_i.pulse(E_TMO);
    expect_rep(16'h2cb1);
    check(aborts - a0, 16'h0001);
    to_msgin();
    tselic_initiator_i.pulse(E_TMO);
    expect_rep(16'h2cb2);
    mode_i = 3'h3;
    tselic_initiator_i.pulse(E_SEL);
    tselic_initiator_i.pulse(E_CMD);
    tselic_initiator_i.pulse(E_TMO);
    expect_none();
    mode_i = 3'h5;
    to_msgin();
    tselic_initiator_i.pulse(E_TMO);
    expect_none();
  endtask
  task automatic t_long;
    int a0;
    int b0;
    mode_i = 3'h7;
    to_msgin();
    b0 = acks;
    tselic_initiator_i.send({8'h01, 8'h1e, 8'h00});
    expect_none();
    check(acks - b0, 16'h0003);
    to_msgin();
    a0 = aborts;
    b0 = acks;
    tselic_initiator_i.send({8'h01, 8'h1f, 8'h05, 8'h07});
    expect_rep(16'h67b2);
    check(acks - b0, 16'h0002);
    check(aborts - a0, 16'h0001);
  endtask
  task automatic t_arb;
    mode_i = 3'h6;
    tselic_initiator_i.pulse(E_ARB);
    tselic_initiator_i.pulse(E_SEL);
    expect_rep(16'h6400);
    expect_rep(16'h8000);
    tselic_initiator_i.pulse(E_SEL);
    tselic_initiator_i.pulse(E_LATE);
    tselic_initiator_i.pulse(E_DONE);
    expect_rep(16'h8000);
    expect_rep(16'h6400);
  endtask
  task automatic t_busy;
    int r0;
    r0 = refs;
    mode_i = 3'h7;
    buf_busy_i = 1'b1;
    tselic_initiator_i.pulse(E_SEL);
    tselic_initiator_i.pulse(E_CMD);
    tselic_initiator_i.pulse(E_TRY);
    expect_rep(16'h8400);
    tselic_initiator_i.pulse(E_SELA);
    tselic_initiator_i.pulse(E_MOUT);
    tselic_initiator_i.pulse(E_TRY);
    expect_rep(16'h8500);
    check(refs - r0, 16'h0002);
    buf_busy_i = 1'b0;
    tselic_initiator_i.pulse(E_SEL);
    tselic_initiator_i.pulse(E_CMD);
    tselic_initiator_i.pulse(E_TRY);
    expect_none();
    check(refs - r0, 16'h0002);
  endtask
  // six reports without a read: the sixth is lost, then a reset mid-run
  task automatic t_ovf;
    mode_i = 3'h6;
    repeat (6) tselic_initiator_i.pulse(E_SEL);
    check({15'h0, overflow_o}, 16'h0001);
    repeat (5) expect_rep(16'h8000);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    check({15'h0, overflow_o}, 16'h0000);
    check(report_o, 16'h0000);
  endtask
  task automatic stop_test;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    stop_test();
  end
  initial begin
    rst_i = 1'b1;
    buf_busy_i = 1'b0;
    report_ack_i = 1'b0;
    mode_i = 3'h0;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    check(report_o, 16'h0000);
    t_plain_sel();
    t_timeout();
    t_long();
    t_arb();
    t_busy();
    t_ovf();
    stop_test();
  end
endmodule

bind tselic_top tselic_props tselic_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .ev_i(ev_i), .buf_busy_i(buf_busy_i), .msg_byte_stb_i(msg_byte_stb_i),
  .report_ack_i(report_ack_i), .report_o(report_o),
  .report_valid_o(report_valid_o), .byte_ack_o(byte_ack_o),
  .abort_o(abort_o), .msg_refused_o(msg_refused_o),
  .overflow_o(overflow_o));
